// ### core/tfe_pkg.sv
// Shared constants and carrier types for the exception sequencer
package tfe_pkg;

  localparam int CLK_PERIOD_NS   = 100;
  // Group 0 entry must begin within this many clock cycles
  localparam int G0_START_CYCLES = 2;
  localparam logic [15:0] SR_RESET = 16'h2700;
  localparam int SR_T_BIT        = 15;
  localparam int SR_S_BIT        = 13;
  localparam logic [7:0] VEC_RESET   = 8'h00;
  localparam logic [7:0] VEC_BUSERR  = 8'h02;
  localparam logic [7:0] VEC_ADDRERR = 8'h03;
  localparam logic [7:0] VEC_TRACE   = 8'h09;
  localparam logic [7:0] VEC_SPUR    = 8'h18;
  localparam logic [3:0] FRAME_SHORT = 4'h3;
  localparam logic [3:0] FRAME_LONG  = 4'h7;
  localparam logic [2:0] FRAME_IDX_W = 3'h7;

  typedef enum logic [2:0]
  {
    GRP_NONE, GRP_G0, GRP_G1, GRP_G2
  } tfe_grp_e;

  // Fault report from the bus interface
  typedef struct packed
  {
    logic        bus_err;
    logic        odd_access;
    logic        is_word;
    logic        is_fetch;
    logic        is_read;
    logic [2:0]  fc;
    logic [31:0] addr;
  } tfe_fault_s;

  // Instruction sequencer status
  typedef struct packed
  {
    logic        instr_start;
    logic        instr_done;
    logic        instr_exc;
    logic [7:0]  instr_vec;
    logic        illegal;
    logic        privilege;
    logic        irq_pend;
    logic [7:0]  irq_vec;
    logic        vec_phase;
    logic [31:0] next_pc;
    logic [31:0] instr_pc;
    logic [15:0] opcode;
  } tfe_seq_s;

  // Stack word request to the sequencer
  typedef struct packed
  {
    logic        valid;
    logic [2:0]  index;
    logic [31:0] data;
  } tfe_push_s;

  function automatic logic [31:0] vec_addr(input logic [7:0] v);
    vec_addr = {22'h000000, v, 2'h0};
  endfunction : vec_addr

endpackage : tfe_pkg

// ### core/tfe_frame_mem.sv
// Small frame store holding the stacked context words
`timescale 1ns/100ps
module tfe_frame_mem
  import tfe_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [31:0] wdata,
  input  wire logic [2:0]  raddr,
  output logic      [31:0] rdata
);

  logic [31:0] mem [0:7];

  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end

endmodule : tfe_frame_mem

// ### core/tfe_cnt.sv
// Cycle counter with a selectable top, holding at top, used to pace frame pushing
`timescale 1ns/100ps
module tfe_cnt
  import tfe_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic       en,
  input  wire logic [2:0] top,
  output logic      [2:0] cnt,
  output logic            last
);

  assign last = (cnt == top);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt <= 3'h0;
    else if (load)
      cnt <= 3'h0;
    else if (en && !last)
      cnt <= cnt + 3'h1;
  end

endmodule : tfe_cnt

// ### core/tfe_top.sv
// Trace, bus fault, odd access and exception priority sequencer
`timescale 1ns/100ps
module tfe_top
  import tfe_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire tfe_fault_s  FAULT,
  input  wire tfe_seq_s    SEQ,
  input  wire logic [15:0] STATUS_IN,
  input  wire logic        PUSH_READY,
  input  wire logic [2:0]  FRAME_RADDR,
  output logic             BUS_ABORT,
  output logic             BUS_ENABLE,
  output logic             HALTED,
  output logic             EXC_ACTIVE,
  output logic             EXC_DONE,
  output logic [7:0]       EXC_VECTOR,
  output logic [15:0]      STATUS_OUT,
  output logic             STATUS_LOAD,
  output logic             IRQ_TAKEN,
  output logic             TRAP_CANCEL,
  output tfe_push_s        PUSH,
  output logic [31:0]      FRAME_RDATA
);

  typedef enum
  {
    ST_RUN, ST_ENTER, ST_PUSH, ST_VEC, ST_HALT
  } tfe_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // State

  tfe_state_e  state_q,    state_d;
  tfe_grp_e    grp_q,      grp_d;
  logic        trace_q,    trace_d;
  logic        trpend_q,   trpend_d;
  logic        irqpend_q,  irqpend_d;
  logic [7:0]  vec_q,      vec_d;
  logic [15:0] sr_copy_q,  sr_copy_d;
  logic [31:0] pc_q,       pc_d;
  logic        long_q,     long_d;
  logic [15:0] opc_q,      opc_d;
  logic [31:0] faddr_q,    faddr_d;
  logic [4:0]  finfo_q,    finfo_d;
  logic        abort_q;
  logic        bus_en_q;
  logic        active_q;
  logic        halted_q;
  logic        done_q;
  logic        irq_taken_q;
  logic        cancel_q;
  logic        sr_load_q;
  logic [15:0] sr_out_q;
  tfe_push_s   push_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fault decode and priority

  wire odd_err   = FAULT.odd_access && (FAULT.is_word || FAULT.is_fetch);
  wire bus_err   = FAULT.bus_err && !odd_err;
  wire g0_fault  = odd_err || bus_err;
  wire in_g0     = (state_q != ST_RUN) && (grp_q == GRP_G0);
  // Fault during group 0 entry is a double fault
  wire dbl_fault = g0_fault && in_g0;
  // A halted core ignores every further fault
  wire g0_take   = g0_fault && !dbl_fault && (state_q != ST_HALT);
  wire vec_phase = (state_q == ST_VEC) || SEQ.vec_phase;

  // Trace armed at instruction start, cancelled by illegal or privilege
  wire trace_arm = SEQ.instr_start && STATUS_IN[SR_T_BIT];
  wire trace_ok  = trace_q && !SEQ.illegal && !SEQ.privilege;
  wire fin_trace = SEQ.instr_done && trace_ok && !g0_fault;

  wire g1_ready  = (state_q == ST_RUN) && !g0_fault;
  // Group 1/2 selection: instr exc, then trace, then irq, then illegal
  wire take_g2   = g1_ready && SEQ.instr_exc;
  wire take_tr   = g1_ready && !SEQ.instr_exc
                   && (trpend_q || fin_trace);
  wire take_irq  = g1_ready && !SEQ.instr_exc && !take_tr
                   && (irqpend_q || SEQ.irq_pend)
                   && (SEQ.instr_done || irqpend_q);
  wire take_ill  = g1_ready && !SEQ.instr_exc && !take_tr && !take_irq
                   && (SEQ.illegal || SEQ.privilege);
  wire take_g1   = take_tr || take_irq || take_ill;

  wire [7:0] vec_sel = odd_err  ? VEC_ADDRERR :
                       bus_err  ? VEC_BUSERR  :
                       take_g2  ? SEQ.instr_vec :
                       take_tr  ? VEC_TRACE   :
                       take_irq ? SEQ.irq_vec : SEQ.instr_vec;

  // Supervisor set, trace cleared before vector fetch
  wire [15:0] sr_entry = (STATUS_IN | (16'h0001 << SR_S_BIT))
                         & ~(16'h0001 << SR_T_BIT);

  // Activity flag: instruction in progress unless group 0 or 1 busy
  wire not_instr = (state_q != ST_RUN) &&
                   (grp_q == GRP_G0 || grp_q == GRP_G1);

  // Fault PC: vector address in final entry step or while SEQ.vec_phase is set, else sequencer PC
  wire [31:0] fault_pc = vec_phase ? vec_addr(vec_q) : SEQ.next_pc;

  ////////////////////////////////////////////////////////////////////////////
  // Frame counter and store

  logic [2:0] cnt;
  logic       cnt_last;
  wire        entering = (state_q == ST_ENTER);
  wire        push_go  = (state_q == ST_PUSH) && PUSH_READY;
  wire [2:0]  frame_top = long_q ? FRAME_IDX_W : FRAME_SHORT[2:0];

  tfe_cnt u_cnt
  (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .load  (entering),
    .en    (push_go),
    .top   (frame_top),
    .cnt   (cnt),
    .last  (cnt_last)
  );

  // Frame words: long frame carries fault context ahead of PC and SR
  logic [31:0] word_sel;
  always_comb
  begin
    word_sel = 32'h00000000;
    case (long_q ? cnt : cnt + 3'h4)
      3'h0:    word_sel = {27'h0000000, finfo_q};
      3'h1:    word_sel = faddr_q;
      3'h2:    word_sel = {16'h0000, opc_q};
      3'h3:    word_sel = 32'h00000000;
      3'h4:    word_sel = {16'h0000, sr_copy_q};
      3'h5:    word_sel = pc_q;
      default: word_sel = 32'h00000000;
    endcase
  end

  tfe_frame_mem u_mem
  (
    .clk   (CLOCK),
    .we    (push_go),
    .waddr (cnt),
    .wdata (word_sel),
    .raddr (FRAME_RADDR),
    .rdata (FRAME_RDATA)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    state_d   = state_q;
    grp_d     = grp_q;
    vec_d     = vec_q;
    sr_copy_d = sr_copy_q;
    pc_d      = pc_q;
    long_d    = long_q;
    opc_d     = opc_q;
    faddr_d   = faddr_q;
    finfo_d   = finfo_q;
    // Each start re-samples the trace bit, so a stale arm left by an
    // instruction that never completed cannot leak into the next one
    trace_d   = SEQ.instr_start ? trace_arm :
                (SEQ.instr_done ? 1'b0 : trace_q);
    trpend_d  = trpend_q;
    irqpend_d = irqpend_q;
    case (state_q)
      ST_RUN:
      begin
        if (take_g2)
        begin
          // Trace and irq wait behind the instruction's own exception
          trpend_d  = trpend_q || fin_trace;
          irqpend_d = irqpend_q || (SEQ.irq_pend && SEQ.instr_done);
        end
        else if (take_tr)
        begin
          trpend_d  = 1'b0;
          irqpend_d = irqpend_q || (SEQ.irq_pend && SEQ.instr_done);
        end
        else if (take_irq)
          irqpend_d = 1'b0;
      end
      ST_PUSH:
        if (push_go && cnt_last)
          state_d = ST_VEC;
      ST_VEC:
      begin
        // Group drops after this step; a fault in this step is a fresh group 0 entry unless a group 0 entry is finishing, which halts as a double fault
        grp_d   = GRP_NONE;
        state_d = ST_RUN;
      end
      ST_ENTER:
        state_d = ST_PUSH;
      // Only RST_N leaves the halt state
      ST_HALT:
        state_d = ST_HALT;
      default:
        state_d = ST_RUN;
    endcase
    if ((state_q == ST_RUN) && (take_g2 || take_g1))
    begin
      state_d   = ST_ENTER;
      grp_d     = take_g2 ? GRP_G2 : GRP_G1;
      vec_d     = vec_sel;
      sr_copy_d = STATUS_IN;
      pc_d      = take_ill ? SEQ.instr_pc : SEQ.next_pc;
      long_d    = 1'b0;
      if (take_tr)
        trace_d = 1'b0;
    end
    if (g0_take)
    begin
      state_d   = ST_ENTER;
      grp_d     = GRP_G0;
      vec_d     = vec_sel;
      sr_copy_d = STATUS_IN;
      pc_d      = fault_pc;
      long_d    = 1'b1;
      opc_d     = SEQ.opcode;
      faddr_d   = FAULT.addr;
      finfo_d   = {FAULT.is_read, not_instr, FAULT.fc};
      trace_d   = 1'b0;
      trpend_d  = 1'b0;
    end
    if (dbl_fault)
      state_d = ST_HALT;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      // Reset wipes every pending exception and starts group 0 entry
      state_q     <= ST_VEC;
      grp_q       <= GRP_G0;
      vec_q       <= VEC_RESET;
      trace_q     <= 1'b0;
      trpend_q    <= 1'b0;
      irqpend_q   <= 1'b0;
      sr_copy_q   <= SR_RESET;
      pc_q        <= 32'h00000000;
      long_q      <= 1'b0;
      opc_q       <= 16'h0000;
      faddr_q     <= 32'h00000000;
      finfo_q     <= 5'h00;
    end
    else
    begin
      state_q     <= state_d;
      grp_q       <= grp_d;
      vec_q       <= vec_d;
      trace_q     <= trace_d;
      trpend_q    <= trpend_d;
      irqpend_q   <= irqpend_d;
      sr_copy_q   <= sr_copy_d;
      pc_q        <= pc_d;
      long_q      <= long_d;
      opc_q       <= opc_d;
      faddr_q     <= faddr_d;
      finfo_q     <= finfo_d;
    end
  end

  // Outputs all registered; abort lands one edge after the fault,
  // inside the two-cycle group 0 window
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      abort_q     <= 1'b0;
      halted_q    <= 1'b0;
      bus_en_q    <= 1'b1;
      active_q    <= 1'b1;
      done_q      <= 1'b0;
      irq_taken_q <= 1'b0;
      cancel_q    <= 1'b0;
      sr_load_q   <= 1'b1;
      sr_out_q    <= SR_RESET;
      push_q      <= '0;
    end
    else
    begin
      abort_q     <= g0_fault && (state_q != ST_HALT);
      halted_q    <= (state_d == ST_HALT);
      // Registered so the bus side sees a clean level from a flop
      bus_en_q    <= (state_d != ST_HALT);
      active_q    <= (state_d != ST_RUN) && (state_d != ST_HALT);
      done_q      <= (state_q == ST_VEC);
      irq_taken_q <= take_irq && !take_g2;
      cancel_q    <= g0_take && SEQ.instr_exc;
      sr_load_q   <= g0_take || ((take_g1 || take_g2) && !g0_fault);
      // Tracks the entry word between loads so it is ready on the strobe
      sr_out_q    <= sr_load_q && !(g0_take || take_g1 || take_g2)
                     ? sr_out_q : sr_entry;
      push_q      <= '{valid: push_go, index: cnt, data: word_sel};
    end
  end

  assign BUS_ABORT   = abort_q;
  assign BUS_ENABLE  = bus_en_q;
  assign HALTED      = halted_q;
  assign EXC_ACTIVE  = active_q;
  assign EXC_DONE    = done_q;
  assign EXC_VECTOR  = vec_q;
  assign STATUS_OUT  = sr_out_q;
  assign STATUS_LOAD = sr_load_q;
  assign IRQ_TAKEN   = irq_taken_q;
  assign TRAP_CANCEL = cancel_q;
  assign PUSH        = push_q;

endmodule : tfe_top

// ### dv/tfe_props.sv
// Port checks for the exception sequencer
`timescale 1ns/100ps
module tfe_props
  import tfe_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire tfe_fault_s  FAULT,
  input wire tfe_seq_s    SEQ,
  input wire logic [15:0] STATUS_IN,
  input wire logic        PUSH_READY,
  input wire logic        BUS_ABORT,
  input wire logic        BUS_ENABLE,
  input wire logic        HALTED,
  input wire logic        EXC_ACTIVE,
  input wire logic        EXC_DONE,
  input wire logic [7:0]  EXC_VECTOR,
  input wire logic [15:0] STATUS_OUT,
  input wire logic        STATUS_LOAD,
  input wire logic        TRAP_CANCEL,
  input wire tfe_push_s   PUSH
);
  localparam int G0_MAX = G0_START_CYCLES;
  logic g0_q;
  logic trace_q;
  wire  odd_w  = FAULT.odd_access && (FAULT.is_word || FAULT.is_fetch);
  wire  flt_w  = FAULT.bus_err || odd_w;
  wire  free_w = !EXC_ACTIVE && !HALTED;
  wire  arm_w  = SEQ.instr_start ? STATUS_IN[SR_T_BIT] : trace_q;
  ////////////////////////////////////////
  // Reset entry counts as group 0 until its done pulse
  always_ff @(posedge CLOCK)
  begin
    g0_q    <= !RST_N || BUS_ABORT || (g0_q && !EXC_DONE);
    trace_q <= RST_N && arm_w && !(SEQ.instr_done && !SEQ.instr_start);
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  AST_G0_ABORT: assert property (flt_w && free_w |=> BUS_ABORT)
    else $error("fault not aborted");
  AST_G0_START: assert property
    (flt_w && free_w |-> ##[1:G0_MAX] STATUS_LOAD)
    else $error("group 0 entry late");
  AST_ODD_VEC: assert property
    (odd_w && free_w |=> ##1 EXC_VECTOR == VEC_ADDRERR)
    else $error("odd access vector wrong");
  AST_BUS_VEC: assert property
    (FAULT.bus_err && !odd_w && free_w |=> ##1 EXC_VECTOR == VEC_BUSERR)
    else $error("bus error vector wrong");
  AST_SUPER: assert property
    (STATUS_LOAD |-> STATUS_OUT[SR_S_BIT] && !STATUS_OUT[SR_T_BIT])
    else $error("entry status not supervisor");
  AST_DOUBLE: assert property
    (flt_w && EXC_ACTIVE && (g0_q || BUS_ABORT) |=> HALTED)
    else $error("double fault did not halt");
  AST_HALT_STAY: assert property
    (HALTED |-> !BUS_ENABLE ##1 HALTED && !BUS_ABORT)
    else $error("halted core still active");
  AST_PUSH_PACE: assert property
    (PUSH.valid |-> $past(PUSH_READY))
    else $error("word pushed without ready");
  AST_TRACE: assert property
    (SEQ.instr_done && trace_q && free_w && !flt_w && !SEQ.instr_exc &&
     !SEQ.illegal && !SEQ.privilege |-> ##[1:4] EXC_VECTOR == VEC_TRACE)
    else $error("trace not raised");
  AST_TRAP_CANCEL: assert property
    (SEQ.instr_exc && FAULT.bus_err && free_w |-> ##[1:2] TRAP_CANCEL)
    else $error("trap not abandoned");
  cover property ($rose(HALTED));
  cover property (EXC_DONE && EXC_VECTOR == VEC_TRACE);
  cover property (TRAP_CANCEL);
endmodule : tfe_props

bind tfe_top tfe_props u_props
(
  .CLOCK(CLOCK), .RST_N(RST_N), .FAULT(FAULT), .SEQ(SEQ),
  .STATUS_IN(STATUS_IN), .PUSH_READY(PUSH_READY), .BUS_ABORT(BUS_ABORT),
  .BUS_ENABLE(BUS_ENABLE), .HALTED(HALTED), .EXC_ACTIVE(EXC_ACTIVE),
  .EXC_DONE(EXC_DONE), .EXC_VECTOR(EXC_VECTOR), .STATUS_OUT(STATUS_OUT),
  .STATUS_LOAD(STATUS_LOAD), .TRAP_CANCEL(TRAP_CANCEL), .PUSH(PUSH)
);

// ### dv/tfe_seq_model.sv
// Sequencer side model taking stacked words
`timescale 1ns/100ps
module tfe_seq_model
  import tfe_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      slow,
  input  wire tfe_push_s push,
  output logic           push_ready,
  output logic    [31:0] words [8]
);
  // Slow mode stalls every other cycle to stretch frame pushing
  initial push_ready = 1'b0;
  always @(negedge clk)
    push_ready <= slow ? !push_ready : 1'b1;
  always @(posedge clk)
    if (push.valid === 1'b1)
      words[push.index] <= push.data;
endmodule : tfe_seq_model

// ### dv/tb.sv
// Self-checking bench for the exception sequencer
`timescale 1ns/100ps
module tb
  import tfe_pkg::*;
;
  logic        CLOCK = 1'b0;
  logic        RST_N = 1'b0;
  tfe_fault_s  fault = '0;
  tfe_seq_s    seq   = '0;
  logic [15:0] status_in = SR_RESET;
  logic [2:0]  raddr = 3'h0;
  logic        slow  = 1'b0;
  logic        ready, abort, bus_en, halted, active, done;
  logic        st_load, irq_tk, cancel;
  logic [7:0]  vector;
  logic [15:0] status_out;
  tfe_push_s   push;
  logic [31:0] rdata;
  logic [31:0] words [8];
  int          fails = 0, total_checks = 0;
  int          n_load, n_abort, n_cancel, n_irq, n_push;
  always #50 CLOCK = ~CLOCK;
  tfe_top dut
  (
    .CLOCK(CLOCK), .RST_N(RST_N), .FAULT(fault), .SEQ(seq),
    .STATUS_IN(status_in), .PUSH_READY(ready), .FRAME_RADDR(raddr),
    .BUS_ABORT(abort), .BUS_ENABLE(bus_en), .HALTED(halted),
    .EXC_ACTIVE(active), .EXC_DONE(done), .EXC_VECTOR(vector),
    .STATUS_OUT(status_out), .STATUS_LOAD(st_load), .IRQ_TAKEN(irq_tk),
    .TRAP_CANCEL(cancel), .PUSH(push), .FRAME_RDATA(rdata)
  );
  tfe_seq_model u_seq
  (
    .clk(CLOCK), .slow(slow), .push(push), .push_ready(ready), .words(words)
  );
  // Counted at the falling edge, where registered outputs are settled
  always @(negedge CLOCK)
    if (RST_N)
    begin
      n_load += (st_load === 1'b1);
      n_abort += (abort === 1'b1);
      n_cancel += (cancel === 1'b1);
      n_irq += (irq_tk === 1'b1);
      n_push += (push.valid === 1'b1);
    end
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_done();
    int i;
    @(negedge CLOCK);
    for (i = 0; i < 60 && done !== 1'b1; i++)
      @(negedge CLOCK);
    if (i == 60)
    begin
      fails++;
      stop_test();
    end
  endtask : wait_done
  task automatic clr();
    n_load = 0;
    n_abort = 0;
    n_cancel = 0;
    n_irq = 0;
    n_push = 0;
  endtask : clr
  // Fault code k is bus error, odd, word, fetch; held one cycle
  task automatic flt(input logic [3:0] k, input logic [31:0] a);
    fault = {k, 1'b1, 3'h5, a};
    @(negedge CLOCK);
    fault = '0;
  endtask : flt
  task automatic start();
    seq.instr_start = 1'b1;
    @(negedge CLOCK);
    seq.instr_start = 1'b0;
  endtask : start
  task automatic do_reset();
    RST_N = 1'b0;
    repeat (6) @(negedge CLOCK);
    check(status_out, SR_RESET);
    check(halted, 1'b0);
    RST_N = 1'b1;
    wait_done();
    check(vector, VEC_RESET);
  endtask : do_reset
  ////////////////////////////////////////
  task automatic sc_bus();
    clr();
    slow = 1'b1;
    status_in = 16'h8000;
    seq.instr_pc = 32'h1000;
    seq.next_pc = 32'h1004;
    seq.opcode = 16'h4E71;
    start();
    seq.instr_done = 1'b1;
    flt(4'hA, 32'h2000);
    seq.instr_done = 1'b0;
    check(abort, 1'b1);
    check(active, 1'b1);
    raddr = 3'h1;
    wait_done();
    check(active, 1'b0);
    check(vector, VEC_BUSERR);
    check(words[0][4:0], 5'h15);
    check(words[1], 32'h2000);
    check(rdata, 32'h2000);
    check(words[2], 32'h4E71);
    check(words[4][15:0], 16'h8000);
    check((words[5] - 32'h1000) inside {[32'h2:32'hA]}, 1'b1);
    repeat (10) @(negedge CLOCK);
    check(n_push, 32'h8);
    check(n_load, 32'h1);
  endtask : sc_bus
  task automatic sc_odd();
    clr();
    slow = 1'b0;
    flt(4'h4, 32'h3001);
    check(abort, 1'b0);
    flt(4'hD, 32'h3003);
    check(abort, 1'b1);
    wait_done();
    check(vector, VEC_ADDRERR);
    check(words[1], 32'h3003);
    check(n_push, 32'h8);
  endtask : sc_odd
  task automatic sc_trace();
    clr();
    seq.irq_vec = 8'h40;
    seq.next_pc = 32'h1100;
    start();
    seq.instr_done = 1'b1;
    seq.irq_pend = 1'b1;
    @(negedge CLOCK);
    seq.instr_done = 1'b0;
    wait_done();
    check(vector, VEC_TRACE);
    check(words[0][15:0], 16'h8000);
    check(words[1], 32'h1100);
    wait_done();
    seq.irq_pend = 1'b0;
    check(vector, 8'h40);
    check(n_irq, 32'h1);
    start();
    seq.instr_done = 1'b1;
    seq.instr_exc = 1'b1;
    seq.instr_vec = 8'h20;
    @(negedge CLOCK);
    seq.instr_done = 1'b0;
    seq.instr_exc = 1'b0;
    wait_done();
    check(vector, 8'h20);
    wait_done();
    check(vector, VEC_TRACE);
    check(n_load, 32'h4);
  endtask : sc_trace
  task automatic sc_illegal();
    clr();
    seq.instr_pc = 32'h1200;
    start();
    seq.illegal = 1'b1;
    seq.instr_vec = 8'h04;
    @(negedge CLOCK);
    seq.illegal = 1'b0;
    wait_done();
    check(vector, 8'h04);
    check(words[1], 32'h1200);
    repeat (10) @(negedge CLOCK);
    check(n_load, 32'h1);
  endtask : sc_illegal
  task automatic sc_trap();
    clr();
    status_in = 16'h0000;
    start();
    seq.instr_exc = 1'b1;
    seq.instr_vec = 8'h21;
    flt(4'h8, 32'h4000);
    seq.instr_exc = 1'b0;
    wait_done();
    check(vector, VEC_BUSERR);
    repeat (10) @(negedge CLOCK);
    check(n_cancel, 32'h1);
    check(n_load, 32'h1);
  endtask : sc_trap
  task automatic sc_double();
    clr();
    flt(4'h8, 32'h5000);
    flt(4'h6, 32'h5002);
    repeat (2) @(negedge CLOCK);
    check(halted, 1'b1);
    check(bus_en, 1'b0);
    clr();
    flt(4'h8, 32'h5004);
    repeat (2) @(negedge CLOCK);
    check(n_abort, 32'h0);
    check(halted, 1'b1);
    do_reset();
    check(halted, 1'b0);
    check(bus_en, 1'b1);
  endtask : sc_double
  initial
  begin
    do_reset();
    sc_bus();
    sc_odd();
    sc_trace();
    sc_illegal();
    sc_trap();
    sc_double();
    stop_test();
  end
endmodule : tb
